// ==== urb_bank.sv ====
// register bank for one serial channel with receive-trigger interrupt
`timescale 1ns/10ps
// Behaviour
// [R01] Enhanced mask, fifo-control, modem-control bits and the fraction need enable bit 4.
// [R02] With divisor enable set, addresses 0/1 hold divisor bytes and 2 the fraction unless key.
// [R03] Reading address 0 gives the received byte, writing it loads the transmit byte.
// [R04] The mask gates receive, transmit, line and modem sources into the source register.
// [R05] In fifo mode the receive interrupt rises at the trigger level and drops below it.
// [R06] The receive source code shows while at trigger and clears with the output below it.
// [R07] Data-ready sets when a byte enters the fifo and clears when it is empty.
// [R08] Enhanced function and the four flow characters are reached only under the key value.
// [R09] Mask bit 0 enables the receive interrupt and resets to zero.
// [R10] The identification register reads at 1 only with divisor on, no key, divisor zero.
module urb_bank
  import urb_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [2:0] addr,
  input  wire logic       cs,
  input  wire logic       rd_stb,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] rx_char,
  input  wire logic       rx_push,
  input  wire logic       tx_empty,
  input  wire logic       line_err,
  input  wire logic       modem_chg,
  output logic      [7:0] rdata_r,
  output logic      [7:0] tx_char_r,
  output logic            tx_load_r,
  output logic            rx_pop_r,
  output logic            irq_r,
  output logic      [7:0] div_low_r,
  output logic      [7:0] div_high_r,
  output logic      [3:0] div_frac_r
);
  logic [7:0]       lcr_r, ier_r, fcr_r, mcr_r, efr_r, feature_control_r, trig_r;
  logic [7:0]       res1_r, res2_r, pau1_r, pau2_r;
  logic [7:0]       rd_nxt;
  logic [5:0]       isr_code;
  logic [CNT_W-1:0] rx_level;
  logic             rx_ready, rx_at_trig, rd, wr, key, dlab, enh, flush, rx_irq;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] want);
    hit = (a == want);
  endfunction : hit

  assign rd    = cs && rd_stb;
  assign wr    = cs && wr_stb;
  assign key   = (lcr_r == LCR_ENH_KEY);
  assign dlab  = lcr_r[LCR_DIV_BIT];
  assign enh   = efr_r[EFR_ENH_BIT];
  assign flush = wr && !dlab && !key && hit(addr, ADDR_SRC) && wdata[1];
  assign rx_irq = ier_r[IER_RX_BIT] && rx_at_trig; // R09

  urb_rx_level i_urb_rx_level (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .push      (rx_push),
    .pop       (rx_pop_r),
    .flush     (flush),
    .trig_lvl  (trig_r),
    .fifo_on   (fcr_r[FCR_EN_BIT]),
    .level_r   (rx_level),
    .ready_r   (rx_ready),
    .at_trig_r (rx_at_trig)
  );

  // fixed priority: line, receive, transmit, modem
  always_comb begin
    isr_code = ISR_NONE;
    if (ier_r[IER_LS_BIT] && line_err) begin
      isr_code = ISR_LSTAT; // R04
    end else if (rx_irq) begin
      isr_code = ISR_RXRDY; // R06
    end else if (ier_r[IER_TX_BIT] && tx_empty) begin
      isr_code = ISR_TXRDY; // R04
    end else if (ier_r[IER_MS_BIT] && modem_chg) begin
      isr_code = ISR_MSTAT; // R04
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lcr_r <= RST_LCR;
      ier_r <= RST_ZERO; // R09
      fcr_r <= RST_ZERO;
      mcr_r <= RST_ZERO;
      trig_r <= RST_TRIG;
      feature_control_r <= RST_ZERO;
    end else if (wr && key) begin
      if (hit(addr, ADDR_HOLD)) begin
        trig_r <= wdata;
      end
      if (hit(addr, ADDR_MASK)) begin
        feature_control_r <= wdata;
      end
      if (hit(addr, ADDR_LINE)) begin
        lcr_r <= wdata;
      end
    end else if (wr) begin
      case (addr)
        ADDR_MASK: begin
          if (!dlab) begin
            ier_r <= enh ? wdata : (wdata & ~IER_ENH_MASK); // R01
          end
        end
        ADDR_SRC: begin
          if (!dlab) begin
            fcr_r <= enh ? wdata : (wdata & ~FCR_ENH_MASK); // R01
          end
        end
        ADDR_LINE: begin
          lcr_r <= wdata;
        end
        ADDR_MODEM: begin
          mcr_r <= enh ? wdata : (wdata & ~MCR_ENH_MASK); // R01
        end
        default: begin
        end
      endcase
    end
  end

  // divisor bytes and fraction
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_low_r  <= RST_ZERO;
      div_high_r <= RST_ZERO;
      div_frac_r <= '0;
    end else if (wr && dlab && !key) begin
      if (hit(addr, ADDR_HOLD)) begin
        div_low_r <= wdata; // R02
      end
      if (hit(addr, ADDR_MASK)) begin
        div_high_r <= wdata; // R02
      end
      if (hit(addr, ADDR_SRC) && enh) begin
        div_frac_r <= wdata[3:0]; // R01 R02
      end
    end
  end

  // enhanced function and flow characters
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      efr_r  <= RST_ZERO;
      res1_r <= RST_ZERO;
      res2_r <= RST_ZERO;
      pau1_r <= RST_ZERO;
      pau2_r <= RST_ZERO;
    end else if (wr && key) begin
      case (addr)
        ADDR_SRC:  efr_r  <= wdata; // R08
        ADDR_RES1: res1_r <= wdata; // R08
        ADDR_RES2: res2_r <= wdata; // R08
        ADDR_PAU1: pau1_r <= wdata; // R08
        ADDR_PAU2: pau2_r <= wdata; // R08
        default: begin
        end
      endcase
    end
  end

  // transmit load and receive pop strobes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_char_r <= RST_ZERO;
      tx_load_r <= 1'b0;
      rx_pop_r  <= 1'b0;
    end else begin
      tx_load_r <= wr && !dlab && !key && hit(addr, ADDR_HOLD); // R03
      rx_pop_r  <= rd && !dlab && !key && hit(addr, ADDR_HOLD); // R03
      if (wr && !dlab && !key && hit(addr, ADDR_HOLD)) begin
        tx_char_r <= wdata; // R03
      end
    end
  end

  always_comb begin
    rd_nxt = RST_ZERO;
    case (addr)
      ADDR_HOLD: begin
        if (key) begin
          rd_nxt = {1'b0, rx_level};
        end else if (dlab) begin
          rd_nxt = div_low_r; // R02
        end else begin
          rd_nxt = rx_char; // R03
        end
      end
      ADDR_MASK: begin
        if (key) begin
          rd_nxt = feature_control_r;
        end else if (dlab) begin
          // id only visible while divisor is zero, else divisor high
          rd_nxt = (div_low_r == RST_ZERO && div_high_r == RST_ZERO) ? DEV_CODE : div_high_r; // R10
        end else begin
          // stored enhanced bits stay hidden while the enable is off
          rd_nxt = enh ? ier_r : (ier_r & ~IER_ENH_MASK); // R01
        end
      end
      ADDR_SRC: begin
        if (key) begin
          rd_nxt = efr_r; // R08
        end else if (dlab) begin
          rd_nxt = enh ? {4'h0, div_frac_r} : RST_ZERO; // R01 R02
        end else begin
          rd_nxt = {{2{fcr_r[FCR_EN_BIT]}}, isr_code}; // R04
        end
      end
      ADDR_LINE: rd_nxt = lcr_r;
      ADDR_MODEM: rd_nxt = key ? res1_r : (enh ? mcr_r : (mcr_r & ~MCR_ENH_MASK)); // R01
      ADDR_LSTAT: rd_nxt = key ? res2_r : {1'b0, tx_empty, tx_empty, 4'h0, rx_ready}; // R07
      ADDR_PAU1:  rd_nxt = key ? pau1_r : RST_ZERO;
      ADDR_PAU2:  rd_nxt = key ? pau2_r : RST_ZERO;
      default:   rd_nxt = RST_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= RST_ZERO;
      irq_r   <= 1'b0;
    end else begin
      irq_r <= (isr_code != ISR_NONE); // R05 R06
      if (rd) begin
        rdata_r <= rd_nxt;
      end
    end
  end

  property p_irq_below;
    @(posedge clk_sys) disable iff (rst)
      (!rx_at_trig && !ier_r[IER_LS_BIT] && !ier_r[IER_TX_BIT] && !ier_r[IER_MS_BIT]) |=> !irq_r;
  endproperty
  a_irq_below: assert property (p_irq_below) else $error("irq stuck below trigger"); // R05

  property p_src_code;
    @(posedge clk_sys) disable iff (rst)
      (rx_irq && !(ier_r[IER_LS_BIT] && line_err)) |-> (isr_code == ISR_RXRDY);
  endproperty
  a_src_code: assert property (p_src_code) else $error("receive code missing"); // R06

  property p_mask_gate;
    @(posedge clk_sys) disable iff (rst)
      (ier_r[3:0] == 4'h0) |=> !irq_r;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked source raised irq"); // R04

  property p_enh_mask;
    @(posedge clk_sys) disable iff (rst)
      (rd && !enh && !dlab && addr == ADDR_MASK) |=> ((rdata_r & IER_ENH_MASK) == 8'h00);
  endproperty
  a_enh_mask: assert property (p_enh_mask) else $error("enhanced mask bits set"); // R01

  property p_div_stable;
    @(posedge clk_sys) disable iff (rst)
      (!dlab || key) |=> $stable(div_low_r);
  endproperty
  a_div_stable: assert property (p_div_stable) else $error("divisor written out of map"); // R02

  property p_efr_key;
    @(posedge clk_sys) disable iff (rst)
      !key |=> $stable(efr_r);
  endproperty
  a_efr_key: assert property (p_efr_key) else $error("enhanced reg written without key"); // R08

  property p_tx_load;
    @(posedge clk_sys) disable iff (rst)
      (wr && !dlab && !key && addr == ADDR_HOLD) |=> (tx_load_r && tx_char_r == $past(wdata));
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("transmit byte not loaded"); // R03

  property p_id_read;
    @(posedge clk_sys) disable iff (rst)
      (rd && dlab && !key && addr == ADDR_MASK && div_low_r == 8'h00 && div_high_r == 8'h00)
        |=> (rdata_r == DEV_CODE);
  endproperty
  a_id_read: assert property (p_id_read) else $error("id not returned"); // R10
endmodule : urb_bank

// ==== urb_pkg.sv ====
// package: register offsets, field positions, reset values and codes for the register bank
package urb_pkg;
  localparam logic [2:0] ADDR_HOLD     = 3'h0;  // receive/transmit holding, divisor low
  localparam logic [2:0] ADDR_MASK     = 3'h1;  // interrupt mask, divisor high
  localparam logic [2:0] ADDR_SRC      = 3'h2;  // interrupt source / fifo control / fraction
  localparam logic [2:0] ADDR_LINE     = 3'h3;
  localparam logic [2:0] ADDR_MODEM    = 3'h4;
  localparam logic [2:0] ADDR_LSTAT    = 3'h5;
  localparam logic [2:0] ADDR_RES1     = 3'h4;
  localparam logic [2:0] ADDR_RES2     = 3'h5;
  localparam logic [2:0] ADDR_PAU1     = 3'h6;
  localparam logic [2:0] ADDR_PAU2     = 3'h7;
  localparam logic [7:0] LCR_ENH_KEY   = 8'hbf;
  localparam int         LCR_DIV_BIT   = 7;
  localparam int         EFR_ENH_BIT   = 4;
  localparam int         FCR_EN_BIT    = 0;
  localparam int         IER_RX_BIT    = 0;
  localparam int         IER_TX_BIT    = 1;
  localparam int         IER_LS_BIT    = 2;
  localparam int         IER_MS_BIT    = 3;
  localparam logic [7:0] IER_ENH_MASK  = 8'hf0;
  localparam logic [7:0] MCR_ENH_MASK  = 8'he0;
  localparam logic [7:0] FCR_ENH_MASK  = 8'h30;
  localparam logic [7:0] DLD_MASK      = 8'h0f;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_LCR       = 8'h00;
  localparam logic [7:0] RST_TRIG      = 8'h01;
  localparam logic [5:0] ISR_NONE      = 6'h01;
  localparam logic [5:0] ISR_LSTAT     = 6'h06;
  localparam logic [5:0] ISR_RXRDY     = 6'h04;
  localparam logic [5:0] ISR_TXRDY     = 6'h02;
  localparam logic [5:0] ISR_MSTAT     = 6'h00;
  localparam logic [7:0] REV_CODE      = 8'h01;  // arbitrary value
  localparam logic [7:0] DEV_CODE      = 8'h5c;  // arbitrary value
  localparam int         FIFO_DEPTH    = 64;
  localparam int         CNT_W         = 7;
endpackage : urb_pkg

// ==== urb_rx_level.sv ====
// receive fifo level tracker: count, trigger compare and data-ready flag
`timescale 1ns/10ps
module urb_rx_level
  import urb_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic             flush,
  input  wire logic [7:0]       trig_lvl,
  input  wire logic             fifo_on,
  output logic      [CNT_W-1:0] level_r,
  output logic                  ready_r,
  output logic                  at_trig_r
);
  logic [CNT_W-1:0] level_nxt;
  logic             do_push;
  logic             do_pop;

  assign do_push = push && (level_r != CNT_W'(FIFO_DEPTH));
  assign do_pop  = pop && (level_r != '0);

  always_comb begin
    level_nxt = level_r;
    if (flush) begin
      // a byte landing in the flush cycle survives it, so set wins over clear
      level_nxt = push ? CNT_W'(1) : '0;
    end else if (do_push && !do_pop) begin
      level_nxt = level_r + CNT_W'(1);
    end else if (do_pop && !do_push) begin
      level_nxt = level_r - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level_r   <= '0;
      ready_r   <= 1'b0;
      at_trig_r <= 1'b0;
    end else begin
      level_r   <= level_nxt;
      ready_r   <= (level_nxt != '0); // R07
      // non-fifo mode: one character is the trigger
      at_trig_r <= fifo_on ? ({1'b0, level_nxt} >= trig_lvl) : (level_nxt != '0); // R05
    end
  end

  property p_ready_follows;
    @(posedge clk_sys) disable iff (rst)
      (do_push && !flush) |=> ready_r;
  endproperty
  a_ready_follows: assert property (p_ready_follows) else $error("ready not set on push"); // R07

  property p_ready_empty;
    @(posedge clk_sys) disable iff (rst)
      ready_r == (level_r != '0);
  endproperty
  a_ready_empty: assert property (p_ready_empty) else $error("ready not tied to level"); // R07
endmodule : urb_rx_level

// ==== urb_host.sv ====
// host model: one-cycle register reads and writes on the parallel bus
`timescale 1ns/10ps
module urb_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] rdata_r,
  output logic      [2:0] addr,
  output logic            cs,
  output logic            rd_stb,
  output logic            wr_stb,
  output logic      [7:0] wdata
);
  initial begin
    addr = 3'h7;
    wdata = 8'h00;
    cs = 1'b0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
  end
  // released lines flip so a stale value never reads as valid
  task automatic idle();
    cs = 1'b0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    addr = ~addr;
    wdata = ~wdata;
  endtask : idle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    addr = a;
    wdata = d;
    cs = 1'b1;
    wr_stb = 1'b1;
    @(posedge clk_sys);
    #1;
    idle();
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    addr = a;
    cs = 1'b1;
    rd_stb = 1'b1;
    @(posedge clk_sys);
    #1;
    d = rdata_r;
    idle();
  endtask : rd
endmodule : urb_host

// ==== tb_urb_bank.sv ====
// testbench for the register bank: banking, holding, trigger interrupt, data ready
`timescale 1ns/10ps
module tb_urb_bank;
  import urb_pkg::*;
  logic       clk_sys, rst, rx_push, tx_empty, line_err, modem_chg, cs, rd_stb, wr_stb;
  logic [2:0] addr;
  logic [7:0] wdata, rx_char, rdata_r, tx_char_r, div_low_r, div_high_r, v;
  logic       tx_load_r, rx_pop_r, irq_r;
  logic [3:0] div_frac_r;
  int         fail_count, cmp_count;
  urb_bank i_urb_bank (.clk_sys(clk_sys), .rst(rst), .addr(addr), .cs(cs), .rd_stb(rd_stb),
    .wr_stb(wr_stb), .wdata(wdata), .rx_char(rx_char), .rx_push(rx_push),
    .tx_empty(tx_empty), .line_err(line_err), .modem_chg(modem_chg), .rdata_r(rdata_r),
    .tx_char_r(tx_char_r), .tx_load_r(tx_load_r), .rx_pop_r(rx_pop_r), .irq_r(irq_r),
    .div_low_r(div_low_r), .div_high_r(div_high_r), .div_frac_r(div_frac_r));
  urb_host i_urb_host (.clk_sys(clk_sys), .rdata_r(rdata_r), .addr(addr), .cs(cs),
    .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk1
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic push_byte();
    cyc(1);
    rx_push = 1'b1;
    cyc(1);
    rx_push = 1'b0;
  endtask : push_byte
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    i_urb_host.rd(a, v);
    chk8(v, e);
  endtask : rdchk
  task automatic t_reset();
    rdchk(ADDR_MASK, 8'h00);
    rdchk(ADDR_SRC, 8'h01);
  endtask : t_reset
  task automatic t_div();
    i_urb_host.wr(ADDR_LINE, 8'h80);
    rdchk(ADDR_MASK, DEV_CODE);
    i_urb_host.wr(ADDR_SRC, 8'h0f);
    chk8({4'h0, div_frac_r}, 8'h00);
    i_urb_host.wr(ADDR_HOLD, 8'h12);
    i_urb_host.wr(ADDR_MASK, 8'h34);
    rdchk(ADDR_HOLD, 8'h12);
    rdchk(ADDR_MASK, 8'h34);
    chk8(div_low_r ^ div_high_r, 8'h26);
    i_urb_host.wr(ADDR_LINE, 8'h00);
  endtask : t_div
  task automatic t_enh();
    i_urb_host.wr(ADDR_MASK, 8'hf1);
    rdchk(ADDR_MASK, 8'h01);
    i_urb_host.wr(ADDR_LINE, LCR_ENH_KEY);
    i_urb_host.wr(ADDR_SRC, 8'h10);
    for (int i = 4; i < 8; i++) i_urb_host.wr(3'(i), 8'(8'h90 + i));
    for (int i = 4; i < 8; i++) rdchk(3'(i), 8'(8'h90 + i));
    i_urb_host.wr(ADDR_LINE, 8'h00);
    i_urb_host.wr(ADDR_MASK, 8'hf0);
    rdchk(ADDR_MASK, 8'hf0);
    i_urb_host.wr(ADDR_MASK, 8'h00);
    i_urb_host.wr(ADDR_MODEM, 8'h03);
    rdchk(ADDR_MODEM, 8'h03);
    i_urb_host.wr(ADDR_LINE, 8'h80);
    i_urb_host.wr(ADDR_SRC, 8'h0a);
    chk8({4'h0, div_frac_r}, 8'h0a);
    rdchk(ADDR_SRC, 8'h0a);
    i_urb_host.wr(ADDR_LINE, 8'h00);
  endtask : t_enh
  task automatic t_hold();
    i_urb_host.wr(ADDR_HOLD, 8'h55);
    chk1(tx_load_r, 1'b1);
    chk8(tx_char_r, 8'h55);
    push_byte();
    rdchk(ADDR_HOLD, 8'ha5);
    chk1(rx_pop_r, 1'b1);
  endtask : t_hold
  task automatic t_trig();
    i_urb_host.wr(ADDR_SRC, 8'h01);
    i_urb_host.wr(ADDR_LINE, LCR_ENH_KEY);
    i_urb_host.wr(ADDR_HOLD, 8'h03);
    i_urb_host.wr(ADDR_LINE, 8'h00);
    push_byte();
    push_byte();
    cyc(3);
    rdchk(ADDR_LSTAT, 8'h01);
    push_byte();
    cyc(3);
    chk1(irq_r, 1'b0);
    i_urb_host.wr(ADDR_MASK, 8'h01);
    cyc(2);
    chk1(irq_r, 1'b1);
    rdchk(ADDR_SRC, 8'hc4);
    rdchk(ADDR_HOLD, 8'ha5);
    cyc(3);
    chk1(irq_r, 1'b0);
    rdchk(ADDR_SRC, 8'hc1);
    rdchk(ADDR_HOLD, 8'ha5);
    rdchk(ADDR_HOLD, 8'ha5);
    cyc(3);
    rdchk(ADDR_LSTAT, 8'h00);
    line_err = 1'b1;
    i_urb_host.wr(ADDR_MASK, 8'h05);
    cyc(2);
    chk1(irq_r, 1'b1);
    rdchk(ADDR_SRC, 8'hc6);
  endtask : t_trig
  task automatic t_misc();
    line_err = 1'b0;
    tx_empty = 1'b1;
    i_urb_host.wr(ADDR_MASK, 8'h02);
    cyc(2);
    chk1(irq_r, 1'b1);
    rdchk(ADDR_SRC, 8'hc2);
    rdchk(ADDR_LSTAT, 8'h60);
    tx_empty = 1'b0;
    modem_chg = 1'b1;
    i_urb_host.wr(ADDR_MASK, 8'h08);
    cyc(2);
    chk1(irq_r, 1'b1);
    rdchk(ADDR_SRC, 8'hc0);
    modem_chg = 1'b0;
    cyc(2);
    chk1(irq_r, 1'b0);
    // non-fifo mode: one waiting byte raises the receive interrupt
    i_urb_host.wr(ADDR_SRC, 8'h00);
    i_urb_host.wr(ADDR_MASK, 8'h01);
    push_byte();
    cyc(3);
    chk1(irq_r, 1'b1);
    rdchk(ADDR_SRC, 8'h04);
    push_byte();
    i_urb_host.wr(ADDR_SRC, 8'h03);
    cyc(2);
    chk1(irq_r, 1'b0);
    rdchk(ADDR_LSTAT, 8'h00);
    push_byte();
    i_urb_host.wr(ADDR_LINE, LCR_ENH_KEY);
    rdchk(ADDR_HOLD, 8'h01);
    i_urb_host.wr(ADDR_MASK, 8'h5a);
    rdchk(ADDR_MASK, 8'h5a);
    i_urb_host.wr(ADDR_LINE, 8'h00);
    rdchk(ADDR_MASK, 8'h01);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk1(irq_r, 1'b0);
    rdchk(ADDR_MASK, 8'h00);
    rdchk(ADDR_LSTAT, 8'h00);
    i_urb_host.wr(ADDR_LINE, 8'h80);
    rdchk(ADDR_MASK, DEV_CODE);
    i_urb_host.wr(ADDR_SRC, 8'h05);
    rdchk(ADDR_SRC, 8'h00);
    i_urb_host.wr(ADDR_LINE, 8'h00);
  endtask : t_misc
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    // far-side datapath levels held quiet except where a scenario drives them
    rst = 1'b1;
    rx_push = 1'b0;
    rx_char = 8'ha5;
    tx_empty = 1'b0;
    line_err = 1'b0;
    modem_chg = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    cyc(6);
    rst = 1'b0;
    t_reset();
    t_div();
    t_enh();
    t_hold();
    t_trig();
    t_misc();
    give_verdict();
  end
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule : tb_urb_bank
